// ==== hdl/bls_pkg.sv ====
// package: constants, codes and carrier types for the buck and logic-rail supervisor
package bls_pkg;
   // ************************************************************
   // switching-period counters
   // ************************************************************
   localparam int OCP_FAULT_PERIODS = 16;
   localparam int OCP_CLEAR_PERIODS = 3;
   localparam int CLK_FREQ_HZ = 100_000_000;
   localparam int FSW_LOW_HZ = 500_000;
   localparam int FSW_HIGH_HZ = 1_000_000;
   localparam logic [7:0] PERIOD_LOW_CYC = 8'(CLK_FREQ_HZ / FSW_LOW_HZ);
   localparam logic [7:0] PERIOD_HIGH_CYC = 8'(CLK_FREQ_HZ / FSW_HIGH_HZ);
   localparam int DEAD_TIME_NS = 20;
   localparam logic [7:0] DEAD_CYC = 8'((DEAD_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000);
   localparam logic [7:0] MAX_ON_LOW_CYC = 8'(PERIOD_LOW_CYC - 8'h10);
   localparam logic [7:0] MAX_ON_HIGH_CYC = 8'(PERIOD_HIGH_CYC - 8'h10);
   // ************************************************************
   // power-up timing
   // ************************************************************
   localparam int TON_DLY_US = 100;
   localparam int TON_DLY_CYC = TON_DLY_US * (CLK_FREQ_HZ / 1_000_000);
   localparam int SS_STEP_CYC = 64;
   // ************************************************************
   // codes
   // ************************************************************
   localparam logic [1:0] SETPT_7V = 2'h3;
   localparam logic [1:0] SETPT_10V = 2'h2;
   localparam logic [1:0] SETPT_12V = 2'h0;
   localparam logic [1:0] SETPT_15V = 2'h1;
   // buck target in tenths of a volt
   localparam logic [7:0] BUCK_65 = 8'h41;
   localparam logic [7:0] BUCK_70 = 8'h46;
   localparam logic [7:0] BUCK_80 = 8'h50;
   localparam logic LOGIC_RAIL_33 = 1'b0;
   localparam logic LOGIC_RAIL_50 = 1'b1;
   localparam int FAULT_BUCK_OCP_BIT = 0;
   localparam int FAULT_BUCK_OVP_BIT = 1;
   localparam int FUNC_RAIL_LEVEL_BIT = 0;
   localparam int FUNC_RAIL_ON_BIT = 1;

   typedef struct packed {
      logic high_on;
      logic low_on;
   } bls_switch_type;

   typedef struct packed {
      logic [1:0] gate_voltage_setpoint;
      logic buck_freq_select;
      logic logic_rail_setpoint;
      logic rail_from_cfg;
      logic [1:0] logic_rail_softstart_cfg;
   } bls_cfg_type;
endpackage

// ==== hdl/bls_sync.sv ====
// two-flop synchroniser for asynchronous comparator levels
`timescale 1ns/10ps
`default_nettype none
module bls_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_sync_out;

   // first stage is read only by the second stage
   always_comb begin
      next_stage1 = async_in;
      next_sync_out = stage1;
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= next_stage1;
         sync_out <= next_sync_out;
      end
   end
endmodule
`default_nettype wire

// ==== hdl/bls_softstart.sv ====
// logic-rail power-up delay and soft-start ramp
`timescale 1ns/10ps
`default_nettype none
module bls_softstart #(
   parameter int TON_DLY = bls_pkg::TON_DLY_CYC
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic buck_uvlo_ok,
   input wire logic analog_load_done,
   input wire logic [1:0] ramp_cfg,
   output logic ramp_enable,
   output logic [7:0] ramp_level
);
   logic [15:0] dly_cnt;
   logic [15:0] next_dly_cnt;
   logic [9:0] step_cnt;
   logic [9:0] next_step_cnt;
   logic [7:0] next_ramp_level;
   logic next_ramp_enable;
   logic [9:0] step_len;

   // ramp speed: each cfg step doubles the time per level
   always_comb begin
      step_len = 10'(bls_pkg::SS_STEP_CYC) << ramp_cfg;
   end

   // delay counts only while the buck rail stays above its rising level
   always_comb begin
      next_dly_cnt = dly_cnt;
      next_step_cnt = step_cnt;
      next_ramp_level = ramp_level;
      next_ramp_enable = ramp_enable;
      if (!buck_uvlo_ok) begin
         next_dly_cnt = '0;
      end else if (dly_cnt < 16'(TON_DLY)) begin
         next_dly_cnt = dly_cnt + 16'h0001;
      end
      // start only when delay done and analog loading done
      if (!ramp_enable && dly_cnt >= 16'(TON_DLY) && analog_load_done) begin // RQ15
         next_ramp_enable = 1'b1;
      end
      if (ramp_enable && ramp_level != 8'hff) begin // RQ16
         if (step_cnt + 10'h001 >= step_len) begin
            next_step_cnt = '0;
            next_ramp_level = ramp_level + 8'h01;
         end else begin
            next_step_cnt = step_cnt + 10'h001;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         dly_cnt <= '0;
         step_cnt <= '0;
         ramp_level <= '0;
         ramp_enable <= 1'b0;
      end else begin
         dly_cnt <= next_dly_cnt;
         step_cnt <= next_step_cnt;
         ramp_level <= next_ramp_level;
         ramp_enable <= next_ramp_enable;
      end
   end
endmodule
`default_nettype wire

// ==== hdl/bls_supervisor.sv ====
// top: buck switching control, over-current/over-voltage supervision, rail setup
//
// Contract
// RQ1: when peak current hits the limit the high-side pulse ends for the rest of the period.
// RQ2: after truncation the low side turns on only after a dead time.
// RQ3: sixteen consecutive over-current periods raise the buck over-current fault.
// RQ4: the raised fault pulls the active-low alert pin low.
// RQ5: after the fault the buck keeps switching in current limit.
// RQ6: three clean periods in a row clear the period counter without a fault.
// RQ7: the fault sets the buck over-current flag in the fault status word.
// RQ8: output over-voltage turns both switches off at once.
// RQ9: setpoint 11 gives 7 V drive/6.5 V buck, 10 gives 10 V drive/7 V buck.
// RQ10: setpoint 00 gives 12 V drive, 01 gives 15 V, both with an 8 V buck.
// RQ11: a frequency select picks 500 kHz or 1 MHz switching.
// RQ12: the controller should change frequency only through one-time configuration; the code reads buck_freq_select live every cycle.
// RQ13: the logic rail level comes from a resistor strap or a config bit.
// RQ14: the selected logic rail level is reported in the function status word.
// RQ15: logic rail soft-start begins after the buck delay and analog loading are done.
// RQ16: a config field selects the logic rail ramp timing.
// RQ17: gate-driver faults never stop the buck or logic rail.
`timescale 1ns/10ps
`default_nettype none
module bls_supervisor #(
   parameter int TON_DLY = bls_pkg::TON_DLY_CYC,
   parameter int OCP_FAULT_N = bls_pkg::OCP_FAULT_PERIODS,
   parameter int OCP_CLEAR_N = bls_pkg::OCP_CLEAR_PERIODS
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire bls_pkg::bls_cfg_type cfg,
   input wire logic peak_current_cmp,
   input wire logic overvoltage_cmp,
   input wire logic buck_uvlo_ok_cmp,
   input wire logic rail_strap_5v,
   input wire logic analog_load_done,
   input wire logic gate_driver_fault,
   input wire logic fault_clear,
   output bls_pkg::bls_switch_type buck_switch,
   output logic fault_alert_out_n,
   output logic fault_alert_oe_n,
   output logic [1:0] fault_status_reg,
   output logic [1:0] function_status_reg,
   output logic [7:0] buck_target,
   output logic [3:0] gate_drive_voltage,
   output logic logic_rail_enable,
   output logic [7:0] logic_rail_ramp
);
   // ************************************************************
   // synchronise analog comparator levels
   // ************************************************************
   logic [2:0] cmp_sync;
   bls_sync #(.WIDTH(3)) u_sync (
      .clk_sys(clk_sys),
      .reset(reset),
      .async_in({peak_current_cmp, overvoltage_cmp, buck_uvlo_ok_cmp}),
      .sync_out(cmp_sync)
   );
   logic ocp_hit;
   logic ovp_hit;
   logic uvlo_ok;
   assign ocp_hit = cmp_sync[2];
   assign ovp_hit = cmp_sync[1];
   assign uvlo_ok = cmp_sync[0];

   // ************************************************************
   // switching period state machine
   // ************************************************************
   typedef enum logic [3:0] {
      ST_HIGH = 4'b0001,
      ST_DEAD_HL = 4'b0010,
      ST_LOW = 4'b0100,
      ST_OFF = 4'b1000
   } bls_phase_type;

   bls_phase_type phase;
   bls_phase_type next_phase;
   logic [7:0] period_cnt;
   logic [7:0] next_period_cnt;
   logic [7:0] dead_cnt;
   logic [7:0] next_dead_cnt;
   logic ocp_seen;
   logic next_ocp_seen;
   logic [7:0] period_len;
   logic [7:0] on_len;
   logic period_end;
   bls_pkg::bls_switch_type next_buck_switch;

   // frequency select is read every cycle, so a runtime change also resizes the current period
   always_comb begin
      period_len = cfg.buck_freq_select ? bls_pkg::PERIOD_HIGH_CYC
                                        : bls_pkg::PERIOD_LOW_CYC; // RQ11
      on_len = cfg.buck_freq_select ? bls_pkg::MAX_ON_HIGH_CYC : bls_pkg::MAX_ON_LOW_CYC;
      period_end = (period_cnt + 8'h01 >= period_len);
   end

   // gate_driver_fault is deliberately not an input to this logic
   always_comb begin
      next_phase = phase;
      next_period_cnt = period_end ? 8'h00 : period_cnt + 8'h01;
      next_dead_cnt = dead_cnt;
      next_ocp_seen = period_end ? 1'b0 : ocp_seen;
      case (phase)
         ST_HIGH: begin
            if (ocp_hit || period_cnt >= on_len) begin // RQ1
               next_phase = ST_DEAD_HL;
               next_dead_cnt = 8'h00;
               next_ocp_seen = ocp_hit | ocp_seen;
            end
         end
         ST_DEAD_HL: begin
            if (dead_cnt + 8'h01 >= bls_pkg::DEAD_CYC) begin // RQ2
               next_phase = ST_LOW;
            end else begin
               next_dead_cnt = dead_cnt + 8'h01;
            end
         end
         ST_LOW: begin
            // no dead time at period end: the low side hands straight over to the high side
            if (period_end) begin // RQ1 RQ5
               next_phase = ST_HIGH;
            end
         end
         ST_OFF: begin
            if (!ovp_hit && period_end) begin
               next_phase = ST_HIGH;
            end
         end
         default: next_phase = ST_OFF;
      endcase
      if (ovp_hit) begin // RQ8
         next_phase = ST_OFF;
      end
      next_buck_switch.high_on = (next_phase == ST_HIGH);
      next_buck_switch.low_on = (next_phase == ST_LOW); // RQ2
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         phase <= ST_OFF;
         period_cnt <= 8'h00;
         dead_cnt <= 8'h00;
         ocp_seen <= 1'b0;
         buck_switch <= '0;
      end else begin
         phase <= next_phase;
         period_cnt <= next_period_cnt;
         dead_cnt <= next_dead_cnt;
         ocp_seen <= next_ocp_seen;
         buck_switch <= next_buck_switch;
      end
   end

   // ************************************************************
   // over-current period counting and fault
   // ************************************************************
   logic [4:0] ocp_cnt;
   logic [4:0] next_ocp_cnt;
   logic [1:0] clean_cnt;
   logic [1:0] next_clean_cnt;
   logic ocp_flag;
   logic next_ocp_flag;
   logic ovp_flag;
   logic next_ovp_flag;
   logic ocp_this_period;

   // the fault never stops switching: current limit continues
   always_comb begin
      ocp_this_period = ocp_seen | (phase == ST_HIGH && ocp_hit);
      next_ocp_cnt = ocp_cnt;
      next_clean_cnt = clean_cnt;
      next_ocp_flag = ocp_flag;
      next_ovp_flag = ovp_flag | ovp_hit;
      if (fault_clear) begin
         next_ocp_flag = 1'b0;
         next_ovp_flag = ovp_hit;
      end
      if (period_end) begin
         if (ocp_this_period) begin
            next_clean_cnt = 2'h0;
            if (ocp_cnt + 5'h01 >= 5'(OCP_FAULT_N)) begin // RQ3
               next_ocp_cnt = 5'h00;
               next_ocp_flag = 1'b1; // RQ7 set wins over clear
            end else begin
               next_ocp_cnt = ocp_cnt + 5'h01;
            end
         end else if (clean_cnt + 2'h1 >= 2'(OCP_CLEAR_N)) begin // RQ6
            next_clean_cnt = 2'h0;
            next_ocp_cnt = 5'h00;
         end else begin
            next_clean_cnt = clean_cnt + 2'h1;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ocp_cnt <= 5'h00;
         clean_cnt <= 2'h0;
         ocp_flag <= 1'b0;
         ovp_flag <= 1'b0;
      end else begin
         ocp_cnt <= next_ocp_cnt;
         clean_cnt <= next_clean_cnt;
         ocp_flag <= next_ocp_flag;
         ovp_flag <= next_ovp_flag;
      end
   end

   // ************************************************************
   // setpoint decode, rail level and status outputs
   // ************************************************************
   function automatic logic [7:0] buck_of(input logic [1:0] code);
      case (code)
         bls_pkg::SETPT_7V: buck_of = bls_pkg::BUCK_65; // RQ9
         bls_pkg::SETPT_10V: buck_of = bls_pkg::BUCK_70; // RQ9
         default: buck_of = bls_pkg::BUCK_80; // RQ10
      endcase
   endfunction

   function automatic logic [3:0] drive_of(input logic [1:0] code);
      case (code)
         bls_pkg::SETPT_7V: drive_of = 4'h7;
         bls_pkg::SETPT_10V: drive_of = 4'ha;
         bls_pkg::SETPT_12V: drive_of = 4'hc; // RQ10
         default: drive_of = 4'hf; // RQ10
      endcase
   endfunction

   logic strap_sync;
   logic rail_level;
   bls_sync #(.WIDTH(1)) u_strap (
      .clk_sys(clk_sys),
      .reset(reset),
      .async_in(rail_strap_5v),
      .sync_out(strap_sync)
   );
   // strap or config bit chooses the logic rail level
   assign rail_level = cfg.rail_from_cfg ? cfg.logic_rail_setpoint : strap_sync; // RQ13

   logic ss_enable;
   logic [7:0] ss_level;
   bls_softstart #(.TON_DLY(TON_DLY)) u_ss (
      .clk_sys(clk_sys),
      .reset(reset),
      .buck_uvlo_ok(uvlo_ok),
      .analog_load_done(analog_load_done),
      .ramp_cfg(cfg.logic_rail_softstart_cfg),
      .ramp_enable(ss_enable),
      .ramp_level(ss_level)
   );

   // registered outputs; gate_driver_fault only informs, never gates supplies
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         fault_alert_out_n <= 1'b0;
         fault_alert_oe_n <= 1'b1;
         fault_status_reg <= 2'h0;
         function_status_reg <= 2'h0;
         buck_target <= bls_pkg::BUCK_80;
         gate_drive_voltage <= 4'hc;
         logic_rail_enable <= 1'b0;
         logic_rail_ramp <= 8'h00;
      end else begin
         fault_alert_out_n <= 1'b0;
         fault_alert_oe_n <= ~(next_ocp_flag | gate_driver_fault); // RQ4
         fault_status_reg <= {next_ovp_flag, next_ocp_flag}; // RQ7
         function_status_reg <= {ss_enable, rail_level}; // RQ14
         buck_target <= buck_of(cfg.gate_voltage_setpoint);
         gate_drive_voltage <= drive_of(cfg.gate_voltage_setpoint);
         logic_rail_enable <= ss_enable; // RQ17
         logic_rail_ramp <= ss_level;
      end
   end

   // ************************************************************
   // assertions and covers
   // ************************************************************
   a_trunc_on_ocp: assert property (@(posedge clk_sys) disable iff (reset) // RQ1
      (phase == ST_HIGH && ocp_hit && !ovp_hit) |=> !buck_switch.high_on)
      else $error("high side not truncated");
   a_dead_before_low: assert property (@(posedge clk_sys) disable iff (reset) // RQ2
      $rose(buck_switch.low_on) |-> $past(!buck_switch.high_on))
      else $error("low side on without dead time");
   a_no_overlap: assert property (@(posedge clk_sys) disable iff (reset) // RQ2
      !(buck_switch.high_on && buck_switch.low_on))
      else $error("switch overlap");
   a_fault_count: assert property (@(posedge clk_sys) disable iff (reset) // RQ3
      (period_end && ocp_this_period && ocp_cnt == 5'(OCP_FAULT_N - 1)) |=> ocp_flag)
      else $error("fault not raised at count");
   a_alert_pin: assert property (@(posedge clk_sys) disable iff (reset) // RQ4
      ocp_flag |-> !fault_alert_oe_n)
      else $error("alert pin released with fault");
   a_keep_switching: assert property (@(posedge clk_sys) disable iff (reset) // RQ5
      (ocp_flag && phase == ST_LOW && period_end && !ovp_hit) |=> buck_switch.high_on)
      else $error("buck stopped after fault");
   a_clean_reset: assert property (@(posedge clk_sys) disable iff (reset) // RQ6
      (period_end && !ocp_this_period && clean_cnt == 2'(OCP_CLEAR_N - 1)) |=> ocp_cnt == 0)
      else $error("counter not cleared");
   a_flag_status: assert property (@(posedge clk_sys) disable iff (reset) // RQ7
      ocp_flag |-> fault_status_reg[bls_pkg::FAULT_BUCK_OCP_BIT])
      else $error("status flag missing");
   a_ovp_off: assert property (@(posedge clk_sys) disable iff (reset) // RQ8
      ovp_hit |=> (buck_switch == '0))
      else $error("switches on under over-voltage");
   a_setpoint_map: assert property (@(posedge clk_sys) disable iff (reset) // RQ9
      $stable(cfg.gate_voltage_setpoint) && cfg.gate_voltage_setpoint == bls_pkg::SETPT_7V
      |=> buck_target == bls_pkg::BUCK_65)
      else $error("buck target wrong");
   a_rail_status: assert property (@(posedge clk_sys) disable iff (reset) // RQ14
      ##1 function_status_reg[bls_pkg::FUNC_RAIL_LEVEL_BIT] == $past(rail_level))
      else $error("rail level status wrong");
   a_ss_gate: assert property (@(posedge clk_sys) disable iff (reset) // RQ15
      $rose(ss_enable) |-> $past(analog_load_done))
      else $error("soft-start without analog load");

   c_ocp_fault: cover property (@(posedge clk_sys) disable iff (reset) $rose(ocp_flag));
   c_ovp_off: cover property (@(posedge clk_sys) disable iff (reset) $rose(ovp_hit));
   c_clean_clear: cover property (@(posedge clk_sys) disable iff (reset)
      period_end && !ocp_this_period && clean_cnt == 2'h2 && ocp_cnt != 0);
   c_rail_on: cover property (@(posedge clk_sys) disable iff (reset) $rose(logic_rail_enable));
endmodule
`default_nettype wire

// ==== tb/bls_plant.sv ====
// partner model: buck power stage with peak-current comparator and switch timing checks
`timescale 1ns/10ps
`default_nettype none
module bls_plant (
   input wire logic clk_sys,
   input wire logic reset,
   input wire bls_pkg::bls_switch_type buck_switch,
   input wire logic overload,
   input wire logic [3:0] trip_delay,
   output logic peak_current_cmp,
   output logic [7:0] violations
);
   logic [7:0] on_cyc;
   logic [7:0] off_cyc;
   logic [2:0] trip_cyc;
   logic low_q;
   // ****************
   // inductor current and switch watch
   // ****************
   // current only climbs while the high side conducts, so the trip moves with the pulse
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         on_cyc <= 8'h00;
         off_cyc <= 8'h00;
         trip_cyc <= 3'h0;
         low_q <= 1'b0;
         peak_current_cmp <= 1'b0;
         violations <= 8'h00;
      end else begin
         on_cyc <= buck_switch.high_on ? on_cyc + 8'h01 : 8'h00;
         off_cyc <= (buck_switch.high_on || off_cyc == 8'hff) ? 8'h00 : off_cyc + 8'h01;
         peak_current_cmp <= overload && buck_switch.high_on && (on_cyc >= {4'h0, trip_delay});
         trip_cyc <= (peak_current_cmp && buck_switch.high_on) ? trip_cyc + 3'h1 : 3'h0;
         low_q <= buck_switch.low_on;
         // pulse must end a few cycles after the trip
         if (trip_cyc >= 3'h5) begin
            violations <= violations + 8'h01;
         end
         // low side only after the dead time, never with the high side
         if ((buck_switch.low_on && !low_q && off_cyc < bls_pkg::DEAD_CYC)
             || (buck_switch.high_on && buck_switch.low_on)) begin
            violations <= violations + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb/buck_ldo_supervisor_test.sv ====
// testbench: supervisor driven against the power-stage model with a queue of expectations
`timescale 1ns/10ps
`default_nettype none
module buck_ldo_supervisor_test;
   typedef struct packed {
      logic [3:0] sel;
      logic [7:0] value;
   } bls_note_type;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   // switching frequency is rewritten only while reset is held, never live
   bls_pkg::bls_cfg_type cfg = '{2'h0, 1'b1, 1'b0, 1'b1, 2'h0};
   logic overvoltage_cmp = 1'b0;
   logic buck_uvlo_ok_cmp = 1'b1;
   logic rail_strap_5v = 1'b0;
   logic analog_load_done = 1'b0;
   logic gate_driver_fault = 1'b0;
   logic fault_clear = 1'b0;
   logic overload = 1'b0;
   logic [3:0] trip_delay = 4'h5;
   logic peak_current_cmp;
   bls_pkg::bls_switch_type buck_switch;
   logic fault_alert_out_n;
   logic fault_alert_oe_n;
   logic [1:0] fault_status_reg;
   logic [1:0] function_status_reg;
   logic [7:0] buck_target;
   logic [3:0] gate_drive_voltage;
   logic logic_rail_enable;
   logic [7:0] logic_rail_ramp;
   logic [7:0] violations;
   logic [7:0] tgt [4] = '{8'h50, 8'h50, 8'h46, 8'h41};
   logic [7:0] drv [4] = '{8'h0c, 8'h0f, 8'h0a, 8'h07};
   logic [2:0] rail_case [4] = '{3'b110, 3'b001, 3'b010, 3'b101};
   bls_note_type note_q[$];
   bls_note_type cur_note;
   int errors = 0;
   int check_count = 0;
   int cycles = 0;
   int t0;
   int seed;

   bls_supervisor #(.TON_DLY(20)) bls_supervisor_i (
      .clk_sys(clk_sys), .reset(reset), .cfg(cfg), .peak_current_cmp(peak_current_cmp),
      .overvoltage_cmp(overvoltage_cmp), .buck_uvlo_ok_cmp(buck_uvlo_ok_cmp),
      .rail_strap_5v(rail_strap_5v), .analog_load_done(analog_load_done),
      .gate_driver_fault(gate_driver_fault), .fault_clear(fault_clear),
      .buck_switch(buck_switch), .fault_alert_out_n(fault_alert_out_n),
      .fault_alert_oe_n(fault_alert_oe_n), .fault_status_reg(fault_status_reg),
      .function_status_reg(function_status_reg), .buck_target(buck_target),
      .gate_drive_voltage(gate_drive_voltage), .logic_rail_enable(logic_rail_enable),
      .logic_rail_ramp(logic_rail_ramp)
   );
   bls_plant bls_plant_i (
      .clk_sys(clk_sys), .reset(reset), .buck_switch(buck_switch), .overload(overload),
      .trip_delay(trip_delay), .peak_current_cmp(peak_current_cmp), .violations(violations)
   );

   // ****************
   // clock, timeout and result watcher
   // ****************
   always #5 clk_sys = ~clk_sys;
   // the ceiling is several times the ~5000 cycles the sequence needs
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         errors = errors + 1;
         end_of_test();
      end
   end
   // notes are taken at the falling edge so registered outputs have settled
   always @(negedge clk_sys) begin
      if (note_q.size() > 0) begin
         cur_note = note_q.pop_front();
         check(observe(cur_note.sel), cur_note.value);
      end
   end

   function automatic logic [7:0] observe(input logic [3:0] sel);
      case (sel)
         4'h0: return buck_target;
         4'h1: return {4'h0, gate_drive_voltage};
         4'h2: return {6'h00, fault_status_reg};
         4'h3: return {6'h00, function_status_reg};
         4'h4: return {7'h00, fault_alert_oe_n};
         4'h5: return {6'h00, buck_switch};
         4'h6: return {7'h00, logic_rail_enable};
         4'h7: return violations;
         4'h9: return logic_rail_ramp;
         default: return {7'h00, fault_alert_out_n};
      endcase
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] expected);
      check_count = check_count + 1;
      if (seen !== expected) begin
         errors = errors + 1;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, expected);
      end
   endtask

   task automatic note(input logic [3:0] sel, input logic [7:0] value);
      note_q.push_back('{sel, value});
      @(posedge clk_sys);
   endtask

   task automatic wait_cycles(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // waits for n rising high-side pulses; a new random trip point each period
   task automatic wait_periods(input int n);
      int guard;
      repeat (n) begin
         guard = 0;
         trip_delay <= 4'(5 + $urandom % 8);
         while (buck_switch.high_on !== 1'b0 && guard < 300) begin
            @(posedge clk_sys);
            guard++;
         end
         while (buck_switch.high_on !== 1'b1 && guard < 600) begin
            @(posedge clk_sys);
            guard++;
         end
         if (guard >= 600) begin
            errors = errors + 1;
            $display("unexpected at %0t: switching stalled", $time);
         end
      end
   endtask

   task automatic pulse_clear();
      fault_clear <= 1'b1;
      @(posedge clk_sys);
      fault_clear <= 1'b0;
      wait_cycles(3);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ****************
   // main sequence
   // ****************
   initial begin
      seed = $urandom(32'h73884650);
      wait_cycles(6);
      reset <= 1'b0;
      @(posedge clk_sys);
      note(4'h0, 8'h50);
      note(4'h4, 8'h01);
      note(4'h2, 8'h00);
      cfg.logic_rail_softstart_cfg <= 2'($urandom % 4);
      // rail must wait for analog loading even long after the buck is up
      wait_cycles(60);
      note(4'h6, 8'h00);
      analog_load_done <= 1'b1;
      wait_cycles(40);
      note(4'h6, 8'h01);
      note(4'h3, 8'h02);
      // 650 cycles of ramp since enable, well clear of a step boundary for every cfg
      wait_cycles(610);
      note(4'h9, 8'(650 / (bls_pkg::SS_STEP_CYC << cfg.logic_rail_softstart_cfg)));
      for (int i = 0; i < 4; i++) begin
         cfg.gate_voltage_setpoint <= 2'(i);
         wait_cycles(3);
         note(4'h0, tgt[i]);
         note(4'h1, drv[i]);
      end
      for (int i = 0; i < 4; i++) begin
         {cfg.rail_from_cfg, cfg.logic_rail_setpoint, rail_strap_5v} <= rail_case[i];
         wait_cycles(5);
         note(4'h3, {6'h00, 1'b1, rail_case[i][2] ? rail_case[i][1] : rail_case[i][0]});
      end
      // ten overloaded periods, three clean ones, then fifteen more must not trip
      wait_periods(1);
      t0 = cycles;
      wait_periods(1);
      check(8'(cycles - t0), bls_pkg::PERIOD_HIGH_CYC);
      overload <= 1'b1;
      wait_periods(10);
      overload <= 1'b0;
      wait_periods(3);
      overload <= 1'b1;
      wait_periods(15);
      wait_cycles(3);
      note(4'h2, 8'h00);
      wait_periods(1);
      wait_cycles(3);
      note(4'h2, 8'h01);
      note(4'h4, 8'h00);
      note(4'h8, 8'h00);
      wait_periods(2);
      note(4'h7, 8'h00);
      overload <= 1'b0;
      wait_periods(1);
      pulse_clear();
      note(4'h2, 8'h00);
      note(4'h4, 8'h01);
      gate_driver_fault <= 1'b1;
      wait_periods(2);
      note(4'h6, 8'h01);
      note(4'h4, 8'h00);
      gate_driver_fault <= 1'b0;
      overvoltage_cmp <= 1'b1;
      wait_cycles(4);
      note(4'h5, 8'h00);
      wait_cycles(40);
      note(4'h5, 8'h00);
      note(4'h2, 8'h02);
      overvoltage_cmp <= 1'b0;
      // let the synchronised comparator fall first, or the clear is overridden
      wait_cycles(3);
      pulse_clear();
      note(4'h2, 8'h00);
      note(4'h7, 8'h00);
      // the low frequency is loaded only across a reset, as a one-time load would be
      reset <= 1'b1;
      cfg.buck_freq_select <= 1'b0;
      wait_cycles(2);
      reset <= 1'b0;
      wait_periods(1);
      t0 = cycles;
      wait_periods(1);
      check(8'(cycles - t0), bls_pkg::PERIOD_LOW_CYC);
      note(4'h2, 8'h00);
      wait_cycles(2);
      end_of_test();
   end
endmodule
`default_nettype wire
